// ==== tts_sequencer.sv ====
// Eight-term trace trigger sequencer with per-term storage qualifiers
//
// Summary of operation
// RULE1: Eight terms, exactly one active at once.
// RULE2: Default primary any to next; term eight never.
// RULE3: Default secondary expressions all never.
// RULE4: Default storage qualifiers all store everything.
// RULE5: Default trigger term is term two.
// RULE6: Complex entry or reset command restores defaults.
// RULE7: Simple trigger: pattern primary of term one.
// RULE8: Simple trigger: term two never, trigger term.
// RULE9: Simple trigger touches only first two terms.
// RULE10: Primary branch destination is any term.
// RULE11: Secondary branch has own expression and destination.
// RULE12: Primary branch waits for its occurrence count.
// RULE13: Trigger term may not be term one.
// RULE14: Trigger raised on entry into trigger term.
// RULE15: Both expressions never holds the term forever.
// RULE16: Active term's qualifier decides storage.
// RULE17: Global storage write sets all terms.
// RULE18: One prestore qualifier covers every term.
// RULE19: Qualifier is all, none, pattern or range.
// RULE20: Windowing stores only between enable and disable.
// RULE21: OR or NOR within sets, then AND/OR.
// RULE22: Primary match outranks secondary match.
`default_nettype none
module tts_sequencer #(
  parameter int CNT_WIDTH = tts_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic busValid,
  input wire logic [tts_pkg::PAT_N-1:0] patHit,
  input wire logic rangeHit,
  input wire logic armHit,
  input wire logic traceRun,
  input wire logic enterComplex,
  input wire logic seqReset,
  input wire logic primWr,
  input wire logic [tts_pkg::TERM_W-1:0] primTerm,
  input wire tts_pkg::tts_expr_t primExpr,
  input wire logic [tts_pkg::TERM_W-1:0] primDest,
  input wire logic [CNT_WIDTH-1:0] primCount,
  input wire logic secWr,
  input wire logic [tts_pkg::TERM_W-1:0] secTerm,
  input wire tts_pkg::tts_expr_t secExpr,
  input wire logic [tts_pkg::TERM_W-1:0] secDest,
  input wire logic stoWr,
  input wire logic stoGlobal,
  input wire logic [tts_pkg::TERM_W-1:0] stoTerm,
  input wire tts_pkg::tts_expr_t stoExpr,
  input wire logic trigWr,
  input wire logic [tts_pkg::TERM_W-1:0] trigSel,
  input wire logic simple_trigger_setup,
  input wire tts_pkg::tts_expr_t simpleExpr,
  input wire logic preWr,
  input wire tts_pkg::tts_expr_t preExpr,
  output logic [tts_pkg::TERM_W-1:0] activeTerm_r,
  output logic [CNT_WIDTH-1:0] occLeft_r,
  output logic [tts_pkg::TERM_W-1:0] trigTerm_r,
  output logic trigger_r,
  output logic triggered_r,
  output logic storeEn_r,
  output logic prestoreEn_r,
  output logic trigSelErr_r
);
  import tts_pkg::*;

  localparam logic [CNT_WIDTH-1:0] CNT_DEF = CNT_WIDTH'(DEFAULT_COUNT);
  localparam logic [CNT_WIDTH-1:0] CNT_1 = CNT_WIDTH'(CNT_ONE);

  tts_expr_t priExpr_r [NUM_TERMS];
  logic [TERM_W-1:0] priDest_r [NUM_TERMS];
  logic [CNT_WIDTH-1:0] priCount_r [NUM_TERMS];
  tts_expr_t secExpr_r [NUM_TERMS];
  logic [TERM_W-1:0] secDest_r [NUM_TERMS];
  tts_expr_t stoExpr_r [NUM_TERMS];
  tts_expr_t preExpr_r;

  logic specDefault;
  logic [TERM_W-1:0] term_nxt;
  logic [CNT_WIDTH-1:0] occ_nxt;
  logic branch;
  logic enterTrig;
  logic lastOcc;
  logic primTake;
  logic primCountDn;
  logic secTake;
  logic stoPass;
  logic prePass;
  logic primHit;
  logic secHit;
  logic stoHit;
  logic preHit;
  logic [SET_W-1:0] resA;
  logic [SET_W-1:0] resB;

  assign specDefault = enterComplex | seqReset; // see RULE6
  // Set A is {range, p4..p1} and set B is {arm, p8..p5}; patterns only
  // meet patterns of their own set before the two sets are joined
  assign resA = {rangeHit, patHit[PAT_HALF-1:0]};
  assign resB = {armHit, patHit[PAT_N-1:PAT_HALF]};

  // Only the active term is evaluated, so one evaluator per expression
  // kind serves all eight terms at the cost of a wide mux
  tts_eval_if priIf ();
  tts_eval_if secIf ();
  tts_eval_if stoIf ();
  tts_eval_if preIf ();

  assign priIf.expr = priExpr_r[activeTerm_r];
  assign priIf.resA = resA;
  assign priIf.resB = resB;
  assign secIf.expr = secExpr_r[activeTerm_r]; // see RULE11
  assign secIf.resA = resA;
  assign secIf.resB = resB;
  assign stoIf.expr = stoExpr_r[activeTerm_r]; // see RULE16
  assign stoIf.resA = resA;
  assign stoIf.resB = resB;
  assign preIf.expr = preExpr_r; // see RULE18
  assign preIf.resA = resA;
  assign preIf.resB = resB;

  tts_expr_eval priEval (.ev(priIf.eval));
  tts_expr_eval secEval (.ev(secIf.eval));
  tts_expr_eval stoEval (.ev(stoIf.eval));
  tts_expr_eval preEval (.ev(preIf.eval));

  assign primHit = priIf.hit;
  assign secHit = secIf.hit;
  assign stoHit = stoIf.hit; // see RULE19
  assign preHit = preIf.hit;

  // Specification store, one generate slice per term
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERMS; gi++) begin : gTerm
      localparam logic [TERM_W-1:0] IDX = TERM_W'(gi);
      localparam logic [TERM_W-1:0] NEXT_T =
        (IDX == LAST_TERM) ? LAST_TERM : TERM_W'(IDX + TERM_STEP);
      localparam tts_expr_t PRI_DEF =
        (IDX == LAST_TERM) ? EXPR_NEVER : EXPR_ANY;

      // Primary branch expression and destination
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          priExpr_r[gi] <= PRI_DEF; // see RULE2
          priDest_r[gi] <= NEXT_T;
        end else if (specDefault) begin
          priExpr_r[gi] <= PRI_DEF; // see RULE2
          priDest_r[gi] <= NEXT_T;
        end else if (simple_trigger_setup && IDX == FIRST_TERM) begin
          priExpr_r[gi] <= simpleExpr; // see RULE7
          priDest_r[gi] <= SIMPLE_DEST_TERM;
        end else if (simple_trigger_setup && IDX == SIMPLE_DEST_TERM) begin
          priExpr_r[gi] <= EXPR_NEVER; // see RULE8
        end else if (primWr && primTerm == IDX) begin
          priExpr_r[gi] <= primExpr;
          priDest_r[gi] <= primDest; // see RULE10
        end
      end

      // Occurrence count; term two keeps its own under a simple trigger
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          priCount_r[gi] <= CNT_DEF;
        end else if (specDefault) begin
          priCount_r[gi] <= CNT_DEF;
        end else if (simple_trigger_setup && IDX == FIRST_TERM) begin
          priCount_r[gi] <= CNT_DEF;
        end else if (simple_trigger_setup && IDX == SIMPLE_DEST_TERM) begin
          priCount_r[gi] <= priCount_r[gi];
        end else if (primWr && primTerm == IDX) begin
          priCount_r[gi] <= primCount; // see RULE12
        end
      end

      // Secondary branch; the simple trigger leaves other terms alone
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          secExpr_r[gi] <= EXPR_NEVER; // see RULE3
          secDest_r[gi] <= FIRST_TERM;
        end else if (specDefault) begin
          secExpr_r[gi] <= EXPR_NEVER; // see RULE3
          secDest_r[gi] <= FIRST_TERM;
        end else if (simple_trigger_setup && IDX <= SIMPLE_DEST_TERM) begin
          secExpr_r[gi] <= EXPR_NEVER; // see RULE8 and RULE9
        end else if (secWr && secTerm == IDX) begin
          secExpr_r[gi] <= secExpr; // see RULE11
          secDest_r[gi] <= secDest;
        end
      end

      // Storage qualifier; the global write reaches every term at once
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          stoExpr_r[gi] <= EXPR_ANY; // see RULE4
        end else if (specDefault) begin
          stoExpr_r[gi] <= EXPR_ANY; // see RULE4
        end else if (stoWr && (stoGlobal || stoTerm == IDX)) begin
          stoExpr_r[gi] <= stoExpr; // see RULE17
        end
      end
    end
  endgenerate

  // Prestore qualifier is shared by all terms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      preExpr_r <= EXPR_NEVER;
    end else if (specDefault) begin
      preExpr_r <= EXPR_NEVER;
    end else if (preWr) begin
      preExpr_r <= preExpr; // see RULE18
    end
  end

  // Trigger term; term one is refused and the old choice is kept
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigTerm_r <= DEFAULT_TRIG_TERM; // see RULE5
    end else if (specDefault) begin
      trigTerm_r <= DEFAULT_TRIG_TERM; // see RULE5 and RULE6
    end else if (simple_trigger_setup) begin
      trigTerm_r <= SIMPLE_DEST_TERM; // see RULE8
    end else if (trigWr && trigSel != FIRST_TERM) begin
      trigTerm_r <= trigSel; // see RULE13
    end
  end

  // Refusal pulse; a higher priority command in the same cycle hides it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigSelErr_r <= 1'b0;
    end else begin
      trigSelErr_r <= trigWr && (trigSel == FIRST_TERM) && !specDefault
                      && !simple_trigger_setup; // see RULE13
    end
  end

  // Branch decision for the state on the bus this cycle. A primary hit
  // that is still counting swallows the state, so the secondary branch
  // cannot steal it. A count of zero behaves as one
  assign lastOcc = (occLeft_r <= CNT_1); // see RULE12
  assign primTake = busValid && primHit && lastOcc;
  assign primCountDn = busValid && primHit && !lastOcc;
  assign secTake = busValid && !primHit && secHit; // see RULE22

  always_comb begin
    term_nxt = activeTerm_r;
    branch = 1'b0;
    occ_nxt = occLeft_r;
    if (primTake) begin
      term_nxt = priDest_r[activeTerm_r]; // see RULE10
      branch = 1'b1;
    end else if (secTake) begin
      term_nxt = secDest_r[activeTerm_r]; // see RULE11
      branch = 1'b1;
    end else if (primCountDn) begin
      occ_nxt = occLeft_r - CNT_1; // see RULE12
    end
    // With both never neither arm fires and the term holds (see RULE15)
    if (branch) begin
      occ_nxt = priCount_r[term_nxt];
    end
  end

  // Active term; an idle trace parks on term one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      activeTerm_r <= FIRST_TERM;
    end else if (specDefault || !traceRun) begin
      activeTerm_r <= FIRST_TERM;
    end else begin
      activeTerm_r <= term_nxt; // see RULE1
    end
  end

  // Occurrences left; reloaded on every entry, a self loop included
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      occLeft_r <= CNT_DEF;
    end else if (specDefault) begin
      occLeft_r <= CNT_DEF;
    end else if (!traceRun) begin
      occLeft_r <= priCount_r[FIRST_TERM];
    end else begin
      occLeft_r <= occ_nxt; // see RULE12
    end
  end

  // Trigger fires on entry, never on leaving the trigger term; a self
  // loop through the secondary branch is not an entry
  assign enterTrig = branch && (term_nxt == trigTerm_r)
                     && (activeTerm_r != trigTerm_r); // see RULE14

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigger_r <= 1'b0;
    end else if (specDefault || !traceRun) begin
      trigger_r <= 1'b0;
    end else begin
      trigger_r <= enterTrig; // see RULE14
    end
  end

  // Sticky until the trace stops or the default is restored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      triggered_r <= 1'b0;
    end else if (specDefault || !traceRun) begin
      triggered_r <= 1'b0;
    end else if (enterTrig) begin
      triggered_r <= 1'b1;
    end
  end

  // Storage uses the term active when the state arrives, so a window
  // opens with the state after the enable match and closes with the
  // state that matches the disable (see RULE20)
  assign stoPass = traceRun && busValid && stoHit; // see RULE16
  // Prestore only picks up states that the term's qualifier passed over
  assign prePass = traceRun && busValid && !stoHit && preHit; // see RULE18

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      storeEn_r <= 1'b0;
    end else begin
      storeEn_r <= stoPass;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prestoreEn_r <= 1'b0;
    end else begin
      prestoreEn_r <= prePass;
    end
  end
endmodule
`default_nettype wire

// ==== tts_pkg.sv ====
// Shared constants and types for the trace trigger sequencer
`default_nettype none
package tts_pkg;
  localparam int NUM_TERMS = 8;
  localparam int TERM_W = 3;
  localparam int SET_W = 5;
  localparam int CNT_W = 16;
  localparam int PAT_N = 8;
  localparam int PAT_HALF = 4;

  // Term numbers are zero based here: index 0 is the first term
  localparam logic [TERM_W-1:0] FIRST_TERM = 3'h0;
  localparam logic [TERM_W-1:0] LAST_TERM = 3'h7;
  localparam logic [TERM_W-1:0] DEFAULT_TRIG_TERM = 3'h1;
  localparam logic [TERM_W-1:0] SIMPLE_DEST_TERM = 3'h1;
  localparam logic [TERM_W-1:0] TERM_STEP = 3'h1;
  localparam logic [CNT_W-1:0] DEFAULT_COUNT = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [SET_W-1:0] SET_EMPTY = 5'h00;

  typedef enum logic [1:0] {EXP_NEVER, EXP_ANY, EXP_RES} tts_kind_t;

  // Set A holds p1..p4 and range, set B holds p5..p8 and arm
  typedef struct packed {
    tts_kind_t kind;
    logic [SET_W-1:0] maskA;
    logic norA;
    logic [SET_W-1:0] maskB;
    logic norB;
    logic orSets;
  } tts_expr_t;

  localparam tts_expr_t EXPR_NEVER = '{EXP_NEVER, SET_EMPTY, 1'b0,
                                       SET_EMPTY, 1'b0, 1'b0};
  localparam tts_expr_t EXPR_ANY = '{EXP_ANY, SET_EMPTY, 1'b0,
                                     SET_EMPTY, 1'b0, 1'b0};
endpackage
`default_nettype wire

// ==== tts_eval_if.sv ====
// Carrier between the sequencer and its expression evaluators
`default_nettype none
interface tts_eval_if;
  import tts_pkg::*;
  tts_expr_t expr;
  logic [SET_W-1:0] resA;
  logic [SET_W-1:0] resB;
  logic hit;
  modport eval (input expr, input resA, input resB, output hit);
  modport user (output expr, output resA, output resB, input hit);
endinterface
`default_nettype wire

// ==== tts_expr_eval.sv ====
// Combinational evaluator of one branch or storage expression
`default_nettype none
module tts_expr_eval (
  tts_eval_if.eval ev
);
  import tts_pkg::*;

  logic hitA;
  logic hitB;
  logic useA;
  logic useB;

  // Within-set OR or NOR first, then the sets are joined (see RULE21)
  always_comb begin
    useA = (ev.expr.maskA != SET_EMPTY);
    useB = (ev.expr.maskB != SET_EMPTY);
    hitA = (|(ev.expr.maskA & ev.resA)) ^ ev.expr.norA;
    hitB = (|(ev.expr.maskB & ev.resB)) ^ ev.expr.norB;
    case (ev.expr.kind)
      EXP_ANY: ev.hit = 1'b1;
      EXP_RES: begin
        if (useA && useB) begin
          ev.hit = ev.expr.orSets ? (hitA | hitB) : (hitA & hitB);
        end else if (useA) begin
          ev.hit = hitA;
        end else if (useB) begin
          ev.hit = hitB;
        end else begin
          ev.hit = 1'b0;
        end
      end
      default: ev.hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== tts_bus_src.sv ====
// Bus state source that stands in front of the sequencer
`default_nettype none
module tts_bus_src (
  input wire logic clk,
  output var logic busValid,
  output var logic [tts_pkg::PAT_N-1:0] patHit,
  output var logic rangeHit,
  output var logic armHit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    busValid = 1'b0;
    {patHit, rangeHit, armHit} = 10'h000;
  end
  // Idle lines carry the inverse of the last state, so stale hits never help
  task automatic send(input logic [9:0] s);
    @(negedge clk);
    busValid = 1'b1;
    {patHit, rangeHit, armHit} = s;
    @(negedge clk);
    busValid = 1'b0;
    {patHit, rangeHit, armHit} = ~s;
  endtask
endmodule
`default_nettype wire

// ==== tts_sequencer_properties.sv ====
// Concurrent checks on the sequencer ports
`default_nettype none
module tts_sequencer_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic busValid,
  input wire logic traceRun,
  input wire logic enterComplex,
  input wire logic seqReset,
  input wire logic trigWr,
  input wire logic [tts_pkg::TERM_W-1:0] trigSel,
  input wire logic simple_trigger_setup,
  input wire logic [tts_pkg::TERM_W-1:0] activeTerm_r,
  input wire logic [tts_pkg::TERM_W-1:0] trigTerm_r,
  input wire logic trigger_r,
  input wire logic triggered_r,
  input wire logic storeEn_r,
  input wire logic prestoreEn_r,
  input wire logic trigSelErr_r
);
  import tts_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_state; traceRun && busValid; endsequence
  sequence s_restore; enterComplex || seqReset; endsequence
  // Higher priority commands in the same cycle overrule a trigger write
  sequence s_sel;
    trigWr && !enterComplex && !seqReset && !simple_trigger_setup;
  endsequence
  property p_entry;
    trigger_r |-> activeTerm_r == $past(trigTerm_r) &&
      activeTerm_r != $past(activeTerm_r);
  endproperty
  a_entry: assert property (p_entry)
    else $error("trigger without entry into trigger term");
  property p_cause; trigger_r |-> $past(traceRun && busValid); endproperty
  a_cause: assert property (p_cause)
    else $error("trigger without a bus state");
  property p_sticky; s_state ##1 trigger_r |-> triggered_r; endproperty
  a_sticky: assert property (p_sticky)
    else $error("triggered flag missing");
  property p_never1; trigTerm_r != FIRST_TERM; endproperty
  a_never1: assert property (p_never1)
    else $error("trigger term is term one");
  property p_refuse;
    s_sel ##0 trigSel == FIRST_TERM |=> trigSelErr_r && $stable(trigTerm_r);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("bad trigger select not refused");
  property p_accept;
    s_sel ##0 trigSel != FIRST_TERM |=>
      !trigSelErr_r && trigTerm_r == $past(trigSel);
  endproperty
  a_accept: assert property (p_accept)
    else $error("trigger select not taken");
  property p_restore; s_restore |=> trigTerm_r == DEFAULT_TRIG_TERM; endproperty
  a_restore: assert property (p_restore)
    else $error("default trigger term not restored");
  property p_quiet;
    !(traceRun && busValid) |=> !trigger_r && !storeEn_r && !prestoreEn_r;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output pulse without a bus state");
  property p_pre; !(storeEn_r && prestoreEn_r); endproperty
  a_pre: assert property (p_pre)
    else $error("prestore on a stored state");
endmodule
bind tts_sequencer tts_sequencer_chk chk_u (.*);
`default_nettype wire

// ==== tts_sequencer_test.sv ====
// Self-checking bench for the trace trigger sequencer
`default_nettype none
module tts_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tts_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, traceRun = 1'b0, enterComplex = 1'b0;
  logic seqReset = 1'b0, primWr = 1'b0, secWr = 1'b0, stoWr = 1'b0;
  logic stoGlobal = 1'b0, trigWr = 1'b0, simple_trigger_setup = 1'b0;
  logic preWr = 1'b0, busValid, rangeHit, armHit;
  logic [PAT_N-1:0] patHit;
  logic [TERM_W-1:0] primTerm = 3'h0, primDest = 3'h0, secTerm = 3'h0;
  logic [TERM_W-1:0] secDest = 3'h0, stoTerm = 3'h0, trigSel = 3'h0;
  logic [CNT_W-1:0] primCount = 16'h0001;
  tts_expr_t primExpr = EXPR_NEVER, secExpr = EXPR_NEVER;
  tts_expr_t stoExpr = EXPR_NEVER, simpleExpr = EXPR_NEVER;
  tts_expr_t preExpr = EXPR_NEVER;
  logic [TERM_W-1:0] activeTerm_r, trigTerm_r;
  logic [CNT_W-1:0] occLeft_r;
  logic trigger_r, triggered_r, storeEn_r, prestoreEn_r, trigSelErr_r;
  int err_total = 0, total_checks = 0;
  tts_sequencer dut_u (.*);
  tts_bus_src src_u (.*);
  always #2 clk = ~clk;
  function automatic tts_expr_t px(input logic [4:0] a);
    return '{EXP_RES, a, 1'b0, SET_EMPTY, 1'b0, 1'b0};
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic hit(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Flags are {trigger, store, prestore, triggered}
  task automatic st(input logic [9:0] s, input logic [2:0] t,
                    input logic [3:0] f);
    src_u.send(s);
    chk("term", t, activeTerm_r);
    chk("flags", f, {trigger_r, storeEn_r, prestoreEn_r, triggered_r});
  endtask
  task automatic park(ref logic s);
    hit(s);
    chk("trig", DEFAULT_TRIG_TERM, trigTerm_r);
    traceRun = 1'b0;
    @(negedge clk);
    chk("term", FIRST_TERM, activeTerm_r);
    chk("done", 1'b0, triggered_r);
    traceRun = 1'b1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #5000;
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    traceRun = 1'b1;
    chk("trig", DEFAULT_TRIG_TERM, trigTerm_r);
    st(10'h000, 3'h1, 4'b1101);
    for (int i = 2; i < 8; i++) st(10'h000, i[2:0], 4'b0101);
    st(10'h3FF, 3'h7, 4'b0101);
    $display("test default done");
    hit(trigWr);
    chk("err", 1'b1, trigSelErr_r);
    chk("trig", DEFAULT_TRIG_TERM, trigTerm_r);
    $display("test trigger select done");
    for (int i = 0; i < 2; i++) begin
      park(seqReset);
      trigSel = 3'h4;
      hit(trigWr);
      primTerm = 3'h1;
      primExpr = px(5'h01);
      primDest = 3'h4;
      primCount = 16'h0002;
      hit(primWr);
      secTerm = 3'h1;
      secExpr = px(5'h02);
      secDest = 3'h6;
      hit(secWr);
      st(10'h000, 3'h1, 4'b0100);
      chk("occ", 16'h0002, occLeft_r);
      if (i == 1) st(10'h008, 3'h6, 4'b0100);
      else begin
        stoTerm = 3'h1;
        hit(stoWr);
        st(10'h00C, 3'h1, 4'b0000);
        chk("occ", 16'h0001, occLeft_r);
        st(10'h004, 3'h4, 4'b1001);
        st(10'h000, 3'h5, 4'b0101);
      end
    end
    $display("test branches done");
    park(enterComplex);
    stoGlobal = 1'b1;
    stoExpr = px(5'h04);
    hit(stoWr);
    stoGlobal = 1'b0;
    trigSel = 3'h5;
    hit(trigWr);
    simpleExpr = px(5'h01);
    hit(simple_trigger_setup);
    chk("trig", SIMPLE_DEST_TERM, trigTerm_r);
    st(10'h008, 3'h0, 4'b0000);
    st(10'h014, 3'h1, 4'b1101);
    st(10'h3FC, 3'h1, 4'b0101);
    preExpr = px(5'h08);
    hit(preWr);
    st(10'h020, 3'h1, 4'b0011);
    st(10'h030, 3'h1, 4'b0101);
    stoTerm = 3'h1;
    stoExpr = px(5'h10);
    hit(stoWr);
    st(10'h002, 3'h1, 4'b0101);
    st(10'h000, 3'h1, 4'b0001);
    $display("test simple trigger done");
    park(seqReset);
    stoGlobal = 1'b1;
    stoExpr = EXPR_NEVER;
    hit(stoWr);
    stoGlobal = 1'b0;
    stoTerm = 3'h1;
    stoExpr = EXPR_ANY;
    hit(stoWr);
    primTerm = 3'h0;
    primExpr = px(5'h01);
    primDest = 3'h1;
    primCount = 16'h0001;
    hit(primWr);
    primTerm = 3'h1;
    primExpr = px(5'h02);
    primDest = 3'h0;
    hit(primWr);
    st(10'h000, 3'h0, 4'b0000);
    st(10'h004, 3'h1, 4'b1001);
    st(10'h000, 3'h1, 4'b0101);
    st(10'h008, 3'h0, 4'b0101);
    st(10'h000, 3'h0, 4'b0001);
    $display("test window done");
    stoTerm = 3'h0;
    stoExpr = '{EXP_RES, 5'h02, 1'b1, 5'h01, 1'b0, 1'b0};
    hit(stoWr);
    st(10'h040, 3'h0, 4'b0101);
    st(10'h048, 3'h0, 4'b0001);
    stoExpr = '{EXP_RES, 5'h02, 1'b1, 5'h10, 1'b0, 1'b1};
    hit(stoWr);
    st(10'h009, 3'h0, 4'b0101);
    st(10'h008, 3'h0, 4'b0001);
    $display("test set logic done");
    results();
  end
endmodule
`default_nettype wire
